/* hw/twowire_target_pkg.sv */
// Register map, field positions, reset values and pin settings of the two-wire target port
package twowire_target_pkg;
	// Register addresses on the special function register bus
	localparam logic [7:0] ADDR_INT_ENABLE_ONE = 8'ha9;
	localparam logic [7:0] ADDR_OWN_ADDRESS    = 8'he9;
	localparam logic [7:0] ADDR_CONTROL_FLAGS  = 8'hea;
	localparam logic [7:0] ADDR_FIRST_RX_BYTE  = 8'heb;
	localparam logic [7:0] ADDR_SECOND_RX_TX   = 8'hec;

	// Field positions
	localparam int BIT_GLOBAL_IRQ_EN  = 6;
	localparam int BIT_PORT_ENABLE    = 0;
	localparam int BIT_HOST_IRQ_EN    = 7;
	localparam int BIT_TX_DONE_IE     = 6;
	localparam int BIT_RX_SECOND_IE   = 5;
	localparam int BIT_RX_FIRST_IE    = 4;
	localparam int BIT_TX_DONE_FLAG   = 2;
	localparam int BIT_RX_SECOND_FLAG = 1;
	localparam int BIT_RX_FIRST_FLAG  = 0;

	// Reset values
	localparam logic [7:0] RESET_INT_ENABLE_ONE = 8'h00;
	localparam logic [7:0] RESET_OWN_ADDRESS    = 8'h64;
	localparam logic [7:0] RESET_CONTROL_FLAGS  = 8'h04;
	localparam logic [7:0] RESET_DATA_BYTE      = 8'h00;

	// Pin function settings required for target operation
	localparam logic [3:0] SCL_MODE_MASK  = 4'hb;
	localparam logic [3:0] SCL_MODE_VALUE = 4'h1;
	localparam logic [3:0] SDA_MODE_VALUE = 4'h0;

	// Serial framing
	localparam int         BYTE_BITS      = 8;
	localparam logic [3:0] BIT_COUNT_FULL = 4'h8;
	localparam logic [1:0] MAX_RX_BYTES   = 2'h2;
endpackage

/* hw/twowire_sync.sv */
// Two flip-flop synchroniser for one asynchronous input
module twowire_sync
(
	// Clock and reset
	input  wire logic clk,
	input  wire logic rst,
	// Data
	input  wire logic async_in,
	output logic      sync_out
);
	logic meta_q;

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			meta_q   <= 1'b1;
			sync_out <= 1'b1;
		end
		else
		begin
			meta_q   <= async_in;
			sync_out <= meta_q;
		end
	end
endmodule

/* hw/twowire_target_port.sv */
// Two-wire serial target port with its special function registers
// Notes on behaviour
// - Global two-wire interrupt enable gates every interrupt request of this port.
// - Address register bits 7..1 hold own address; only matching transactions answered.
// - Address register bit 0 enables the target port.
// - Control bit 6 enables the transmit-done interrupt.
// - Control bit 5 enables the second-byte-received interrupt.
// - Control bit 4 enables the first-byte-received interrupt.
// - Control bit 2 set by hardware after a byte is sent; resets to one.
// - Control bit 1 set when second received byte is captured.
// - Control bit 0 set when first received byte is captured.
// - Writing zero clears a flag; writing one leaves it unchanged.
// - Read-only register returns the first received byte.
// - Reading the shared data register returns the second received byte.
// - Writing the shared data register loads the byte to send, kept separately.
// - After an addressed write start, accept one or two data bytes in order.
// - After an addressed read start, return exactly one data byte.
module twowire_target_port
	import twowire_target_pkg::*;
(
	// Clock and reset
	input  wire logic       SYS_CLK,
	input  wire logic       RST,
	// Special function register bus
	input  wire logic [7:0] SFR_ADDR,
	input  wire logic [7:0] SFR_WDATA,
	input  wire logic       SFR_WE,
	input  wire logic       SFR_RE,
	output logic      [7:0] SFR_RDATA,
	// Pin function settings
	input  wire logic [3:0] SCL_PIN_FUNCTION_SELECT,
	input  wire logic       SCL_PORT_LATCH,
	input  wire logic [3:0] SDA_PIN_FUNCTION_SELECT,
	input  wire logic       SDA_PORT_LATCH,
	// Bus pins
	input  wire logic       SCL_I,
	input  wire logic       SDA_I,
	output logic            SDA_O,
	output logic            SDA_OE,
	// Processor side
	output logic            TWOWIRE_IRQ,
	output logic            HOST_SIDE_IRQ_ENABLE
);
	typedef enum logic [2:0] {
		ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_RX, ST_RX_ACK, ST_TX, ST_TX_ACK, ST_IGNORE
	} bus_state_e;

	bus_state_e state_q, state_d;
	logic [3:0] cnt_q, cnt_d;
	logic [7:0] shift_q, shift_d;
	logic       low_q, low_d;
	logic       rw_q, rw_d;
	logic [1:0] byte_idx_q, byte_idx_d;
	logic [7:0] rx_first_byte_q, rx_first_byte_d;
	logic [7:0] rx_second_byte_q, rx_second_byte_d;
	logic [7:0] tx_byte_q;
	logic       set_tx_done, set_rx_first, set_rx_second;

	logic       twowire_global_irq_enable_q;
	logic [6:0] own_bus_address_q;
	logic       target_port_enable_q;
	logic       host_side_irq_enable_q;
	logic       tx_done_irq_enable_q, rx_second_irq_enable_q, rx_first_irq_enable_q;
	logic       tx_done_flag_q, rx_second_flag_q, rx_first_flag_q;
	logic [7:0] rdata_q;

	// Pin synchronisation and edge detection
	logic scl_s, sda_s, scl_prev_q, sda_prev_q;

	twowire_sync u_sync_scl
	(
		.clk      (SYS_CLK),
		.rst      (RST),
		.async_in (SCL_I),
		.sync_out (scl_s)
	);

	twowire_sync u_sync_sda
	(
		.clk      (SYS_CLK),
		.rst      (RST),
		.async_in (SDA_I),
		.sync_out (sda_s)
	);

	wire scl_rise   = scl_s & ~scl_prev_q;
	wire scl_fall   = ~scl_s & scl_prev_q;
	wire start_cond = scl_s & scl_prev_q & sda_prev_q & ~sda_s;
	wire stop_cond  = scl_s & scl_prev_q & ~sda_prev_q & sda_s;
	wire byte_full  = (cnt_q == BIT_COUNT_FULL);

	wire pins_ok = ((SCL_PIN_FUNCTION_SELECT & SCL_MODE_MASK) == SCL_MODE_VALUE) & SCL_PORT_LATCH
		& (SDA_PIN_FUNCTION_SELECT == SDA_MODE_VALUE) & SDA_PORT_LATCH;
	wire active = pins_ok & target_port_enable_q;
	wire addr_match = (shift_q[7:1] == own_bus_address_q);

	// Register decode
	wire wr_inte = SFR_WE & (SFR_ADDR == ADDR_INT_ENABLE_ONE);
	wire wr_addr = SFR_WE & (SFR_ADDR == ADDR_OWN_ADDRESS);
	wire wr_ctrl = SFR_WE & (SFR_ADDR == ADDR_CONTROL_FLAGS);
	wire wr_data = SFR_WE & (SFR_ADDR == ADDR_SECOND_RX_TX);

	wire [7:0] rd_inte = {1'b0, twowire_global_irq_enable_q, 6'h00};
	wire [7:0] rd_addr = {own_bus_address_q, target_port_enable_q};
	wire [7:0] rd_ctrl = {host_side_irq_enable_q, tx_done_irq_enable_q, rx_second_irq_enable_q,
		rx_first_irq_enable_q, 1'b0, tx_done_flag_q, rx_second_flag_q, rx_first_flag_q};
	wire [7:0] rd_mux  = (SFR_ADDR == ADDR_INT_ENABLE_ONE) ? rd_inte :
		(SFR_ADDR == ADDR_OWN_ADDRESS)   ? rd_addr :
		(SFR_ADDR == ADDR_CONTROL_FLAGS) ? rd_ctrl :
		(SFR_ADDR == ADDR_FIRST_RX_BYTE) ? rx_first_byte_q :
		(SFR_ADDR == ADDR_SECOND_RX_TX)  ? rx_second_byte_q :
		8'h00;

	// A write of one never sets a flag, and a hardware set beats a same-cycle clear
	wire tx_done_flag_d   = set_tx_done
		| (tx_done_flag_q & ~(wr_ctrl & ~SFR_WDATA[BIT_TX_DONE_FLAG]));
	wire rx_second_flag_d = set_rx_second
		| (rx_second_flag_q & ~(wr_ctrl & ~SFR_WDATA[BIT_RX_SECOND_FLAG]));
	wire rx_first_flag_d  = set_rx_first
		| (rx_first_flag_q & ~(wr_ctrl & ~SFR_WDATA[BIT_RX_FIRST_FLAG]));

	wire irq_any = (tx_done_flag_q & tx_done_irq_enable_q)
		| (rx_second_flag_q & rx_second_irq_enable_q)
		| (rx_first_flag_q & rx_first_irq_enable_q);

	assign TWOWIRE_IRQ          = irq_any & twowire_global_irq_enable_q;
	assign HOST_SIDE_IRQ_ENABLE = host_side_irq_enable_q;
	assign SFR_RDATA            = rdata_q;
	assign SDA_O                = 1'b0;
	assign SDA_OE               = low_q;

	// Bus state machine; bits are sampled on rising clock and data changes after falling clock
	always_comb
	begin
		state_d          = state_q;
		cnt_d            = cnt_q;
		shift_d          = shift_q;
		low_d            = low_q;
		rw_d             = rw_q;
		byte_idx_d       = byte_idx_q;
		rx_first_byte_d  = rx_first_byte_q;
		rx_second_byte_d = rx_second_byte_q;
		set_tx_done      = 1'b0;
		set_rx_first     = 1'b0;
		set_rx_second    = 1'b0;
		if (!active)
		begin
			state_d = ST_IDLE;
			low_d   = 1'b0;
		end
		else if (start_cond)
		begin
			state_d    = ST_ADDR;
			cnt_d      = 4'h0;
			low_d      = 1'b0;
			byte_idx_d = 2'h0;
		end
		else if (stop_cond)
		begin
			state_d = ST_IDLE;
			low_d   = 1'b0;
		end
		else
		begin
			case (state_q)
				ST_ADDR, ST_RX:
				begin
					if (scl_rise && !byte_full)
					begin
						shift_d = {shift_q[6:0], sda_s};
						cnt_d   = cnt_q + 4'h1;
					end
					else if (scl_fall && byte_full && state_q == ST_ADDR)
					begin
						if (addr_match)
						begin
							state_d = ST_ADDR_ACK;
							low_d   = 1'b1;
							rw_d    = shift_q[0];
						end
						else
							state_d = ST_IGNORE;
					end
					else if (scl_fall && byte_full)
					begin
						if (byte_idx_q < MAX_RX_BYTES)
						begin
							state_d    = ST_RX_ACK;
							low_d      = 1'b1;
							byte_idx_d = byte_idx_q + 2'h1;
							if (byte_idx_q == 2'h0)
							begin
								rx_first_byte_d = shift_q;
								set_rx_first    = 1'b1;
							end
							else
							begin
								rx_second_byte_d = shift_q;
								set_rx_second    = 1'b1;
							end
						end
						else
							state_d = ST_IGNORE;
					end
				end
				ST_ADDR_ACK:
				begin
					if (scl_fall && rw_q)
					begin
						state_d = ST_TX;
						shift_d = tx_byte_q;
						low_d   = ~tx_byte_q[BYTE_BITS-1];
						cnt_d   = 4'h1;
					end
					else if (scl_fall)
					begin
						state_d = ST_RX;
						low_d   = 1'b0;
						cnt_d   = 4'h0;
					end
				end
				ST_RX_ACK:
				begin
					if (scl_fall)
					begin
						state_d = ST_RX;
						low_d   = 1'b0;
						cnt_d   = 4'h0;
					end
				end
				ST_TX:
				begin
					if (scl_fall && byte_full)
					begin
						state_d = ST_TX_ACK;
						low_d   = 1'b0;
					end
					else if (scl_fall)
					begin
						low_d   = ~shift_q[BYTE_BITS-2];
						shift_d = {shift_q[6:0], 1'b0};
						cnt_d   = cnt_q + 4'h1;
					end
				end
				ST_TX_ACK:
				begin
					// One byte per read; the controller's answer bit is not needed
					if (scl_rise)
					begin
						set_tx_done = 1'b1;
						state_d     = ST_IGNORE;
					end
				end
				default:
				begin
					state_d = state_q;
				end
			endcase
		end
	end

	always_ff @(posedge SYS_CLK or posedge RST)
	begin
		if (RST)
		begin
			state_q          <= ST_IDLE;
			cnt_q            <= 4'h0;
			shift_q          <= RESET_DATA_BYTE;
			low_q            <= 1'b0;
			rw_q             <= 1'b0;
			byte_idx_q       <= 2'h0;
			rx_first_byte_q  <= RESET_DATA_BYTE;
			rx_second_byte_q <= RESET_DATA_BYTE;
			scl_prev_q       <= 1'b1;
			sda_prev_q       <= 1'b1;
		end
		else
		begin
			state_q          <= state_d;
			cnt_q            <= cnt_d;
			shift_q          <= shift_d;
			low_q            <= low_d;
			rw_q             <= rw_d;
			byte_idx_q       <= byte_idx_d;
			rx_first_byte_q  <= rx_first_byte_d;
			rx_second_byte_q <= rx_second_byte_d;
			scl_prev_q       <= scl_s;
			sda_prev_q       <= sda_s;
		end
	end

	always_ff @(posedge SYS_CLK or posedge RST)
	begin
		if (RST)
		begin
			twowire_global_irq_enable_q <= RESET_INT_ENABLE_ONE[BIT_GLOBAL_IRQ_EN];
			own_bus_address_q           <= RESET_OWN_ADDRESS[7:1];
			target_port_enable_q        <= RESET_OWN_ADDRESS[BIT_PORT_ENABLE];
			host_side_irq_enable_q      <= RESET_CONTROL_FLAGS[BIT_HOST_IRQ_EN];
			tx_done_irq_enable_q        <= RESET_CONTROL_FLAGS[BIT_TX_DONE_IE];
			rx_second_irq_enable_q      <= RESET_CONTROL_FLAGS[BIT_RX_SECOND_IE];
			rx_first_irq_enable_q       <= RESET_CONTROL_FLAGS[BIT_RX_FIRST_IE];
			tx_done_flag_q              <= RESET_CONTROL_FLAGS[BIT_TX_DONE_FLAG];
			rx_second_flag_q            <= RESET_CONTROL_FLAGS[BIT_RX_SECOND_FLAG];
			rx_first_flag_q             <= RESET_CONTROL_FLAGS[BIT_RX_FIRST_FLAG];
			tx_byte_q                   <= RESET_DATA_BYTE;
			rdata_q                     <= RESET_DATA_BYTE;
		end
		else
		begin
			if (wr_inte)
				twowire_global_irq_enable_q <= SFR_WDATA[BIT_GLOBAL_IRQ_EN];
			if (wr_addr)
			begin
				own_bus_address_q    <= SFR_WDATA[7:1];
				target_port_enable_q <= SFR_WDATA[BIT_PORT_ENABLE];
			end
			if (wr_ctrl)
			begin
				host_side_irq_enable_q <= SFR_WDATA[BIT_HOST_IRQ_EN];
				tx_done_irq_enable_q   <= SFR_WDATA[BIT_TX_DONE_IE];
				rx_second_irq_enable_q <= SFR_WDATA[BIT_RX_SECOND_IE];
				rx_first_irq_enable_q  <= SFR_WDATA[BIT_RX_FIRST_IE];
			end
			if (wr_data)
				tx_byte_q <= SFR_WDATA;
			tx_done_flag_q   <= tx_done_flag_d;
			rx_second_flag_q <= rx_second_flag_d;
			rx_first_flag_q  <= rx_first_flag_d;
			if (SFR_RE)
				rdata_q <= rd_mux;
		end
	end
endmodule

/* tb/twowire_target_port_props.sv */
// Port assertions of the two-wire target port
module twowire_target_port_props
	import twowire_target_pkg::*;
(
	// Clock and reset
	input wire logic       SYS_CLK,
	input wire logic       RST,
	// Register bus
	input wire logic [7:0] SFR_ADDR,
	input wire logic [7:0] SFR_WDATA,
	input wire logic       SFR_WE,
	input wire logic       SFR_RE,
	input wire logic [7:0] SFR_RDATA,
	// Pins and request
	input wire logic [3:0] SCL_PIN_FUNCTION_SELECT,
	input wire logic       SCL_PORT_LATCH,
	input wire logic [3:0] SDA_PIN_FUNCTION_SELECT,
	input wire logic       SDA_PORT_LATCH,
	input wire logic       SCL_I,
	input wire logic       SDA_OE,
	input wire logic       TWOWIRE_IRQ
);
	timeunit 1ns;
	timeprecision 1ns;
	logic       glob_q;
	logic [2:0] ien_q;
	wire        pins_ok = ((SCL_PIN_FUNCTION_SELECT & SCL_MODE_MASK) == SCL_MODE_VALUE) && SCL_PORT_LATCH
		&& SDA_PIN_FUNCTION_SELECT == SDA_MODE_VALUE && SDA_PORT_LATCH;
	default clocking @(posedge SYS_CLK);
	endclocking
	default disable iff (RST);
	// Shadow of the enables, so the request can be judged without the flags
	always_ff @(posedge SYS_CLK or posedge RST)
		if (RST)
		begin
			glob_q <= 1'b0;
			ien_q  <= 3'h0;
		end
		else if (SFR_WE && SFR_ADDR == ADDR_INT_ENABLE_ONE)
			glob_q <= SFR_WDATA[BIT_GLOBAL_IRQ_EN];
		else if (SFR_WE && SFR_ADDR == ADDR_CONTROL_FLAGS)
			ien_q <= SFR_WDATA[6:4];
	a_bad_pins: assert property (!pins_ok && !$past(pins_ok) |-> !SDA_OE) else $error("drive with bad pins");
	a_oe_scl_low: assert property ($changed(SDA_OE) |-> !$past(SCL_I, 2))
		else $error("data moved in clock high");
	a_oe_hold: assert property ($rose(SDA_OE) |-> SDA_OE[*6]) else $error("low drive too short");
	a_rdata_hold: assert property (!$past(SFR_RE) |-> $stable(SFR_RDATA)) else $error("read data moved");
	a_ctrl_spare: assert property ($past(SFR_RE) && $past(SFR_ADDR) == ADDR_CONTROL_FLAGS |-> !SFR_RDATA[3])
		else $error("spare control bit set");
	a_inte_bits: assert property ($past(SFR_RE) && $past(SFR_ADDR) == ADDR_INT_ENABLE_ONE
		|-> (SFR_RDATA & 8'hbf) == 8'h00) else $error("foreign enable bits read");
	a_irq_global: assert property (!glob_q |-> !TWOWIRE_IRQ) else $error("request without global enable");
	a_irq_enables: assert property (ien_q == 3'h0 |-> !TWOWIRE_IRQ) else $error("request without enable");
endmodule

/* tb/twowire_ctrl_model.sv */
// Bus controller model: makes the link clock and pulls the data line low
module twowire_ctrl_model
(
	// Bus
	output logic      scl,
	output logic      sda_pull,
	input  wire logic sda
);
	timeunit 1ns;
	timeprecision 1ns;
	initial
	begin
		scl      = 1'b1;
		sda_pull = 1'b0;
	end
	// Every exchange opens with its own start
	task automatic start();
		sda_pull = 1'b1;
		#400;
		scl = 1'b0;
	endtask
	// Data moves only mid-low, so the target never sees a false start or stop
	task automatic bit_xfer(input logic b, output logic r);
		#200;
		sda_pull = !b;
		#200;
		scl = 1'b1;
		#200;
		r = sda;
		#200;
		scl = 1'b0;
	endtask
	task automatic byte_xfer(input logic [7:0] d, output logic [7:0] q, output logic ack);
		for (int i = 7; i >= 0; i--)
			bit_xfer(d[i], q[i]);
		bit_xfer(1'b1, ack);
	endtask
	task automatic stop();
		#200;
		sda_pull = 1'b1;
		#200;
		scl = 1'b1;
		#200;
		sda_pull = 1'b0;
		#200;
	endtask
endmodule

/* tb/test_twowire_target_port.sv */
// Self-checking bench of the two-wire target port
module test_twowire_target_port import twowire_target_pkg::*;;
	timeunit 1ns;
	timeprecision 1ns;
	logic       sys_clk, rst, we, re, scl, pull, oe, irq, ack, sdo, hie, scl_latch, sda_latch;
	logic [7:0] addr, wd, rdat, rx;
	logic [3:0] scl_mode, sda_mode;
	int         bad_count, comparisons;
	wire        sda = (!oe || sdo) && !pull;
	twowire_target_port u_twowire_target_port
	(
		.SYS_CLK(sys_clk), .RST(rst), .SFR_ADDR(addr), .SFR_WDATA(wd), .SFR_WE(we), .SFR_RE(re),
		.SFR_RDATA(rdat), .SCL_PIN_FUNCTION_SELECT(scl_mode), .SCL_PORT_LATCH(scl_latch),
		.SDA_PIN_FUNCTION_SELECT(sda_mode), .SDA_PORT_LATCH(sda_latch), .SCL_I(scl), .SDA_I(sda),
		.SDA_O(sdo), .SDA_OE(oe), .TWOWIRE_IRQ(irq), .HOST_SIDE_IRQ_ENABLE(hie)
	);
	twowire_ctrl_model u_twowire_ctrl_model (.scl(scl), .sda_pull(pull), .sda(sda));
	initial
	begin
		sys_clk = 1'b0;
		forever
			#50 sys_clk = !sys_clk;
	end
	task automatic chk(input logic [7:0] e, input logic [7:0] g);
		comparisons++;
		if (g !== e)
		begin
			bad_count++;
			$display("[ERR] %0t exp %h got %h", $time, e, g);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge sys_clk) #1;
		addr = a;
		wd   = d;
		we   = 1'b1;
		@(posedge sys_clk) #1;
		we = 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge sys_clk) #1;
		addr = a;
		re   = 1'b1;
		@(posedge sys_clk) #1;
		re = 1'b0;
		chk(e, rdat);
	endtask
	task automatic lnk(input logic [7:0] d, input logic a);
		u_twowire_ctrl_model.byte_xfer(d, rx, ack);
		chk({7'h0, a}, {7'h0, ack});
	endtask
	task automatic irq_is(input logic e);
		chk({7'h0, e}, {7'h0, irq});
	endtask
	task automatic t_reset();
		rd(ADDR_INT_ENABLE_ONE, RESET_INT_ENABLE_ONE);
		rd(ADDR_OWN_ADDRESS, RESET_OWN_ADDRESS);
		rd(ADDR_CONTROL_FLAGS, RESET_CONTROL_FLAGS);
		wr(ADDR_FIRST_RX_BYTE, 8'hff);
		rd(ADDR_FIRST_RX_BYTE, RESET_DATA_BYTE);
		rd(8'h55, 8'h00);
		$display("reset test done");
	endtask
	task automatic t_write();
		wr(ADDR_OWN_ADDRESS, 8'hb5);
		wr(ADDR_CONTROL_FLAGS, 8'h00);
		wr(ADDR_CONTROL_FLAGS, 8'h07);
		rd(ADDR_CONTROL_FLAGS, 8'h00);
		u_twowire_ctrl_model.start();
		lnk(8'hb4, 1'b0);
		lnk(8'h3c, 1'b0);
		rd(ADDR_CONTROL_FLAGS, 8'h01);
		lnk(8'hc3, 1'b0);
		lnk(8'h99, 1'b1);
		u_twowire_ctrl_model.stop();
		rd(ADDR_FIRST_RX_BYTE, 8'h3c);
		rd(ADDR_SECOND_RX_TX, 8'hc3);
		rd(ADDR_CONTROL_FLAGS, 8'h03);
		wr(ADDR_INT_ENABLE_ONE, 8'h40);
		wr(ADDR_CONTROL_FLAGS, 8'h13);
		irq_is(1'b1);
		wr(ADDR_CONTROL_FLAGS, 8'h22);
		irq_is(1'b1);
		wr(ADDR_CONTROL_FLAGS, 8'h12);
		irq_is(1'b0);
		$display("write test done");
	endtask
	task automatic t_read();
		wr(ADDR_CONTROL_FLAGS, 8'h00);
		wr(ADDR_SECOND_RX_TX, 8'ha7);
		// Bit 2 of the clock pin mode is a don't-care for target operation
		scl_mode = 4'h5;
		u_twowire_ctrl_model.start();
		lnk(8'hb5, 1'b0);
		lnk(8'hff, 1'b1);
		chk(8'ha7, rx);
		lnk(8'hff, 1'b1);
		chk(8'hff, rx);
		u_twowire_ctrl_model.stop();
		rd(ADDR_CONTROL_FLAGS, 8'h04);
		rd(ADDR_SECOND_RX_TX, 8'hc3);
		$display("read test done");
	endtask
	// Foreign address, wrong pin mode, then a disabled port: none may answer
	task automatic t_refuse();
		u_twowire_ctrl_model.start();
		lnk(8'h22, 1'b1);
		u_twowire_ctrl_model.stop();
		@(posedge sys_clk) #1;
		sda_mode = 4'h4;
		u_twowire_ctrl_model.start();
		lnk(8'hb4, 1'b1);
		u_twowire_ctrl_model.stop();
		@(posedge sys_clk) #1;
		sda_mode = SDA_MODE_VALUE;
		scl_latch = 1'b0;
		u_twowire_ctrl_model.start();
		lnk(8'hb4, 1'b1);
		u_twowire_ctrl_model.stop();
		@(posedge sys_clk) #1;
		scl_latch = 1'b1;
		sda_latch = 1'b0;
		u_twowire_ctrl_model.start();
		lnk(8'hb4, 1'b1);
		u_twowire_ctrl_model.stop();
		@(posedge sys_clk) #1;
		sda_latch = 1'b1;
		wr(ADDR_OWN_ADDRESS, 8'hb4);
		u_twowire_ctrl_model.start();
		lnk(8'hb4, 1'b1);
		u_twowire_ctrl_model.stop();
		rd(ADDR_CONTROL_FLAGS, 8'h04);
		$display("refuse test done");
	endtask
	task automatic t_irq();
		wr(ADDR_INT_ENABLE_ONE, 8'hff);
		rd(ADDR_INT_ENABLE_ONE, 8'h40);
		wr(ADDR_CONTROL_FLAGS, 8'h34);
		irq_is(1'b0);
		wr(ADDR_CONTROL_FLAGS, 8'h44);
		irq_is(1'b1);
		wr(ADDR_INT_ENABLE_ONE, 8'h00);
		irq_is(1'b0);
		wr(ADDR_INT_ENABLE_ONE, 8'h40);
		wr(ADDR_CONTROL_FLAGS, 8'h40);
		irq_is(1'b0);
		// The host-side enable is stored only; it must not raise the target request
		wr(ADDR_CONTROL_FLAGS, 8'h80);
		chk(8'h01, {7'h0, hie});
		irq_is(1'b0);
		rd(ADDR_CONTROL_FLAGS, 8'h80);
		$display("interrupt test done");
	endtask
	task automatic final_report();
		$display("comparisons %0d mismatches %0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	// About 0.1 ms of traffic is expected
	initial
	begin
		#1000000;
		bad_count++;
		final_report();
	end
	initial
	begin
		rst      = 1'b1;
		{we, re} = 2'b00;
		addr     = 8'h00;
		wd       = 8'h00;
		scl_mode = SCL_MODE_VALUE;
		sda_mode = SDA_MODE_VALUE;
		scl_latch = 1'b1;
		sda_latch = 1'b1;
		repeat (5) @(posedge sys_clk);
		#1;
		rst = 1'b0;
		t_reset();
		t_write();
		t_read();
		t_refuse();
		t_irq();
		final_report();
	end
endmodule
bind twowire_target_port twowire_target_port_props u_twowire_target_port_props
(
	.SYS_CLK(SYS_CLK), .RST(RST), .SFR_ADDR(SFR_ADDR), .SFR_WDATA(SFR_WDATA), .SFR_WE(SFR_WE),
	.SFR_RE(SFR_RE), .SFR_RDATA(SFR_RDATA), .SCL_PIN_FUNCTION_SELECT(SCL_PIN_FUNCTION_SELECT),
	.SCL_PORT_LATCH(SCL_PORT_LATCH), .SDA_PIN_FUNCTION_SELECT(SDA_PIN_FUNCTION_SELECT),
	.SDA_PORT_LATCH(SDA_PORT_LATCH), .SCL_I(SCL_I), .SDA_OE(SDA_OE), .TWOWIRE_IRQ(TWOWIRE_IRQ)
);
